// *** rtl/mtc_cfg.svh ***
`ifndef MTC_CFG_SVH
`define MTC_CFG_SVH
// ************************************************************
// timing
// ************************************************************
`define MTC_CLK_PS 8000
`define MTC_LSB_PS 250
`define MTC_TO_LSB 65536
`define MTC_DEAD_PS 15000
`define MTC_LSB_PER_CYC (`MTC_CLK_PS / `MTC_LSB_PS)
`define MTC_TO_CYC (`MTC_TO_LSB / `MTC_LSB_PER_CYC)
`define MTC_DEAD_CYC ((`MTC_DEAD_PS + `MTC_CLK_PS - 1) / `MTC_CLK_PS)
`define MTC_HITS_PER_CH 4
`define MTC_START_IDX 8
// ************************************************************
// register offsets
// ************************************************************
`define MTC_ADR_CTRL 8'h00
`define MTC_ADR_STATUS 8'h04
`define MTC_ADR_IRQ_STAT 8'h08
`define MTC_ADR_IRQ_MASK 8'h0c
`define MTC_ADR_DIFF_CMD 8'h10
`define MTC_ADR_DIFF_LAST 8'h14
`define MTC_RES_REGION 3'h1
// ************************************************************
// fields and reset values
// ************************************************************
`define MTC_CTRL_QUEUE 0
`define MTC_CTRL_START_FALL 1
`define MTC_CTRL_STOP1_FALL 2
`define MTC_CTRL_STOP2_FALL 3
`define MTC_CTRL_CAL 4
`define MTC_CTRL_RST 5'h00
`define MTC_IRQ_HIT 0
`define MTC_IRQ_DONE 1
`define MTC_IRQ_TO 2
`define MTC_STAT_RUN 6
`define MTC_STAT_TO 7
`define MTC_STAT_CMD 8
`endif

// *** rtl/mtc_core.sv ***
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`include "mtc_cfg.svh"
// Functional notes
// - two channels, 250 ps steps, sixteen-bit basic range
// - shared start; each channel records up to four stops after it
// - difference between any two of eight stops, or stop and start
// - cross-channel stops resolve differences down to zero
// - same-channel stop under 15 ns after previous one is dropped
// - later-first pairs give a negative difference
// - no last event within 2^16 steps of start means time-out
// - stop1-to-stop2 difference ignores start position, within time-out
// - queuing chains both channels into one eight-hit channel
// - queuing: channel 1 stops overflow into channel 2 storage
// - queuing: every edge on stop 2 input is ignored
// - active edge of each input selectable by configuration
// - each stop input has its own enable pin
// - store four calibrated or eight uncalibrated results
// - both channels share an identical resolution step
// - eight 16-bit result registers; calibrated value takes two
module mtc_core import mtc_pkg::*; (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic start_pin,
    input wire logic stop1_pin,
    input wire logic stop2_pin,
    input wire logic stop1_en_pin,
    input wire logic stop2_en_pin,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq
);
    mtc_core_t st_r;
    mtc_core_t st_nxt;
    logic start_ev;
    logic stop1_ev;
    logic stop2_ev;
    logic [15:0] res_rdata;
    logic mem_we;
    logic [2:0] mem_waddr;
    logic [15:0] mem_wdata;

    // ************************************************************
    // input conditioning, one identical path per input
    // ************************************************************
    mtc_edge_cond u_start (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .ce(ce),
        .pin(start_pin),
        .en_pin(1'b1),
        .falling(st_r.ctrl[`MTC_CTRL_START_FALL]),
        .ev(start_ev)
    );

    mtc_edge_cond u_stop1 (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .ce(ce),
        .pin(stop1_pin),
        .en_pin(stop1_en_pin),
        .falling(st_r.ctrl[`MTC_CTRL_STOP1_FALL]),
        .ev(stop1_ev)
    );

    mtc_edge_cond u_stop2 (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .ce(ce),
        .pin(stop2_pin),
        .en_pin(stop2_en_pin),
        .falling(st_r.ctrl[`MTC_CTRL_STOP2_FALL]),
        .ev(stop2_ev)
    );

    mtc_result_mem u_res (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .ce(ce),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(wb_adr_i[4:2]),
        .rdata(res_rdata)
    );

    function automatic logic [15:0] hit_val(input logic [7:0][15:0] hits, input logic [3:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        if (idx < 4'(`MTC_START_IDX)) begin
            v = hits[idx[2:0]];
        end
        return v;
    endfunction

    // ************************************************************
    // result write port
    // ************************************************************
    logic [2:0] slot_base;
    logic [31:0] diff_ext;

    always_comb begin
        slot_base = st_r.ctrl[`MTC_CTRL_CAL] ? {st_r.slot[2:1], 1'b0} : st_r.slot;
        diff_ext = {{15{st_r.diff_last[16]}}, st_r.diff_last};
        mem_we = (st_r.cmd != CMD_IDLE);
        mem_waddr = (st_r.cmd == CMD_HIGH) ? (slot_base | 3'h1) : slot_base;
        mem_wdata = (st_r.cmd == CMD_HIGH) ? diff_ext[31:16] : diff_ext[15:0];
    end

    // ************************************************************
    // next state
    // ************************************************************
    logic [15:0] stamp;
    logic [2:0] set_irq;
    logic [2:0] clr_irq;
    logic req;
    logic wr;
    logic [31:0] rd;
    logic queue;

    always_comb begin
        st_nxt = st_r;
        set_irq = 3'h0;
        clr_irq = 3'h0;
        rd = 32'h0000_0000;
        queue = st_r.ctrl[`MTC_CTRL_QUEUE];
        stamp = 16'(st_r.tcnt) * 16'(`MTC_LSB_PER_CYC);
        req = wb_cyc_i && wb_stb_i && !st_r.wb_busy && !st_r.wb_ack;
        wr = st_r.wb_ack && wb_cyc_i && wb_stb_i && wb_we_i;

        // measurement sequencing
        if (start_ev) begin
            st_nxt.meas = MS_RUN;
            st_nxt.tcnt = 12'h000;
            st_nxt.cnt1 = 3'h0;
            st_nxt.cnt2 = 3'h0;
            st_nxt.timeout = 1'b0;
        end else if (st_r.meas == MS_RUN) begin
            st_nxt.tcnt = st_r.tcnt + 12'h001;
            if (stop1_ev) begin
                if (st_r.cnt1 != 3'(`MTC_HITS_PER_CH)) begin
                    st_nxt.hits[st_r.cnt1] = stamp;
                    st_nxt.cnt1 = st_r.cnt1 + 3'h1;
                    set_irq[`MTC_IRQ_HIT] = 1'b1;
                end else if (queue && st_r.cnt2 != 3'(`MTC_HITS_PER_CH)) begin
                    st_nxt.hits[3'(`MTC_HITS_PER_CH) + st_r.cnt2] = stamp;
                    st_nxt.cnt2 = st_r.cnt2 + 3'h1;
                    set_irq[`MTC_IRQ_HIT] = 1'b1;
                end
            end
            if (stop2_ev && !queue && st_r.cnt2 != 3'(`MTC_HITS_PER_CH)) begin
                st_nxt.hits[3'(`MTC_HITS_PER_CH) + st_r.cnt2] = stamp;
                st_nxt.cnt2 = st_r.cnt2 + 3'h1;
                set_irq[`MTC_IRQ_HIT] = 1'b1;
            end
            if (st_nxt.cnt1 == 3'(`MTC_HITS_PER_CH) && st_nxt.cnt2 == 3'(`MTC_HITS_PER_CH)) begin
                st_nxt.meas = MS_DONE;
                set_irq[`MTC_IRQ_DONE] = 1'b1;
            end else if (st_r.tcnt == 12'(`MTC_TO_CYC - 1)) begin
                st_nxt.meas = MS_DONE;
                st_nxt.timeout = 1'b1;
                set_irq[`MTC_IRQ_DONE] = 1'b1;
                set_irq[`MTC_IRQ_TO] = 1'b1;
            end
        end

        // difference command sequencing
        case (st_r.cmd)
            CMD_IDLE: begin
                st_nxt.cmd = CMD_IDLE;
            end
            CMD_LOW: begin
                st_nxt.cmd = st_r.ctrl[`MTC_CTRL_CAL] ? CMD_HIGH : CMD_IDLE;
            end
            CMD_HIGH: begin
                st_nxt.cmd = CMD_IDLE;
            end
            default: begin
                st_nxt.cmd = CMD_IDLE;
            end
        endcase

        // register read mux
        if (wb_adr_i[7:5] == `MTC_RES_REGION) begin
            rd = {16'h0000, res_rdata};
        end else begin
            case (wb_adr_i)
                `MTC_ADR_CTRL: begin
                    rd = {27'h0, st_r.ctrl};
                end
                `MTC_ADR_STATUS: begin
                    rd = {26'h0, st_r.cnt2, st_r.cnt1};
                    rd[`MTC_STAT_RUN] = (st_r.meas == MS_RUN);
                    rd[`MTC_STAT_TO] = st_r.timeout;
                    rd[`MTC_STAT_CMD] = (st_r.cmd != CMD_IDLE);
                end
                `MTC_ADR_IRQ_STAT: begin
                    rd = {29'h0, st_r.irq_stat};
                end
                `MTC_ADR_IRQ_MASK: begin
                    rd = {29'h0, st_r.irq_mask};
                end
                `MTC_ADR_DIFF_CMD: begin
                    rd = {21'h0, st_r.slot, st_r.sel_b, st_r.sel_a};
                end
                `MTC_ADR_DIFF_LAST: begin
                    rd = {{15{st_r.diff_last[16]}}, st_r.diff_last};
                end
                default: begin
                    rd = 32'h0000_0000;
                end
            endcase
        end

        // wishbone slave: latch request, answer on the following edge
        st_nxt.wb_ack = 1'b0;
        if (req) begin
            st_nxt.wb_busy = 1'b1;
        end
        if (st_r.wb_busy) begin
            st_nxt.wb_busy = 1'b0;
            st_nxt.wb_ack = 1'b1;
            st_nxt.wb_dat = wb_we_i ? 32'h0000_0000 : rd;
        end
        if (wr && wb_adr_i == `MTC_ADR_CTRL && wb_sel_i[0]) begin
            st_nxt.ctrl = wb_dat_i[4:0];
        end
        if (wr && wb_adr_i == `MTC_ADR_IRQ_MASK && wb_sel_i[0]) begin
            st_nxt.irq_mask = wb_dat_i[2:0];
        end
        if (wr && wb_adr_i == `MTC_ADR_IRQ_STAT && wb_sel_i[0]) begin
            clr_irq = wb_dat_i[2:0];
        end
        if (wr && wb_adr_i == `MTC_ADR_DIFF_CMD && st_r.cmd == CMD_IDLE && (|wb_sel_i[1:0])) begin
            st_nxt.sel_a = wb_sel_i[0] ? wb_dat_i[3:0] : st_r.sel_a;
            st_nxt.sel_b = wb_sel_i[0] ? wb_dat_i[7:4] : st_r.sel_b;
            st_nxt.slot = wb_sel_i[1] ? wb_dat_i[10:8] : st_r.slot;
            st_nxt.cmd = CMD_LOW;
            // common start base cancels for stop-to-stop pairs
            st_nxt.diff_last = 17'({1'b0, hit_val(st_r.hits, st_nxt.sel_b)})
                - 17'({1'b0, hit_val(st_r.hits, st_nxt.sel_a)});
        end

        // sticky events, set wins over clear
        st_nxt.irq_stat = (st_r.irq_stat & ~clr_irq) | set_irq;
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
            st_r.ctrl <= `MTC_CTRL_RST;
            st_r.meas <= MS_IDLE;
            st_r.cmd <= CMD_IDLE;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o = st_r.wb_dat;
    assign wb_ack_o = st_r.wb_ack;
    assign irq = st_r.irq;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence wb_req_s;
        ce && wb_cyc_i && wb_stb_i && !st_r.wb_busy && !st_r.wb_ack;
    endsequence

    sequence wb_ans_s;
        ce ##1 st_r.wb_ack;
    endsequence

    wb_answer_a: assert property (wb_req_s |=> wb_ans_s)
        else $error("bus request not acknowledged two edges later");
    start_clears_a: assert property ((ce && start_ev) |=> (st_r.meas == MS_RUN && st_r.cnt1 == 3'h0
        && st_r.cnt2 == 3'h0 && st_r.tcnt == 12'h000)) else $error("start did not open a fresh measurement");
    hit_stamp_a: assert property ((ce && !start_ev && st_r.meas == MS_RUN && stop1_ev
        && st_r.cnt1 != 3'h4) |=> st_r.hits[$past(st_r.cnt1)] == 16'($past(st_r.tcnt)) * 16'(`MTC_LSB_PER_CYC))
        else $error("stop 1 timestamp wrong");
    zero_diff_a: assert property ((ce && !start_ev && st_r.meas == MS_RUN && stop1_ev && stop2_ev
        && !st_r.ctrl[0] && st_r.cnt1 == 3'h0 && st_r.cnt2 == 3'h0) |=> st_r.hits[0] == st_r.hits[4])
        else $error("simultaneous cross channel stops differ");
    timeout_hit_a: assert property ((ce && !start_ev && st_r.meas == MS_RUN && st_r.tcnt == 12'h7ff
        && !(st_nxt.cnt1 == 3'h4 && st_nxt.cnt2 == 3'h4)) |=> (st_r.timeout && st_r.meas == MS_DONE))
        else $error("time-out not raised at window end");
    closed_hold_a: assert property ((ce && st_r.meas != MS_RUN && !start_ev) |=>
        ($stable(st_r.cnt1) && $stable(st_r.cnt2))) else $error("hit recorded outside a measurement");
    queue_ignore_a: assert property ((ce && st_r.ctrl[0] && !stop1_ev && !start_ev) |=>
        $stable(st_r.cnt2)) else $error("stop 2 edge used while queuing");
    queue_route_a: assert property ((ce && !start_ev && st_r.meas == MS_RUN && st_r.ctrl[0]
        && stop1_ev && st_r.cnt1 == 3'h4 && st_r.cnt2 != 3'h4) |=> st_r.cnt2 == $past(st_r.cnt2) + 3'h1)
        else $error("channel 1 overflow not routed");
    cal_pair_a: assert property ((ce && st_r.cmd == CMD_LOW && st_r.ctrl[4]) |=>
        (st_r.cmd == CMD_HIGH && mem_waddr[0])) else $error("calibrated result not written as pair");

    // ************************************************************
    // storage, window and flag checks
    // ************************************************************
    sequence stop2_take_s;
        ce && !start_ev && st_r.meas == MS_RUN && stop2_ev && !st_r.ctrl[`MTC_CTRL_QUEUE]
            && st_r.cnt2 != 3'(`MTC_HITS_PER_CH);
    endsequence

    sequence uncal_low_s;
        ce && st_r.cmd == CMD_LOW && !st_r.ctrl[`MTC_CTRL_CAL];
    endsequence

    sequence mask_write_s;
        ce && wr && wb_adr_i == `MTC_ADR_IRQ_MASK && wb_sel_i[0];
    endsequence

    ack_single_a: assert property ((ce && st_r.wb_ack) |=> !st_r.wb_ack)
        else $error("bus acknowledge held longer than one cycle");
    stop2_stamp_a: assert property (stop2_take_s |=> st_r.hits[3'(`MTC_HITS_PER_CH) + $past(st_r.cnt2)]
        == 16'($past(st_r.tcnt)) * 16'(`MTC_LSB_PER_CYC)) else $error("stop 2 timestamp scale differs");
    hit_limit_a: assert property (st_r.cnt1 <= 3'(`MTC_HITS_PER_CH) && st_r.cnt2 <= 3'(`MTC_HITS_PER_CH))
        else $error("more than four hits counted on a channel");
    run_window_a: assert property ((st_r.meas == MS_RUN) |-> st_r.tcnt <= 12'(`MTC_TO_CYC - 1))
        else $error("measurement timer passed the time-out window");
    done_freeze_a: assert property ((ce && st_r.meas == MS_DONE && !start_ev) |=> $stable(st_r.hits))
        else $error("hit storage changed after the measurement closed");
    uncal_slot_a: assert property (uncal_low_s |-> (mem_we && mem_waddr == st_r.slot))
        else $error("uncalibrated result not written to its own slot");
    uncal_single_a: assert property (uncal_low_s |=> st_r.cmd == CMD_IDLE)
        else $error("uncalibrated result took a second write");
    set_wins_a: assert property ((ce && |set_irq) |=> ((st_r.irq_stat & $past(set_irq)) == $past(set_irq)))
        else $error("event flag lost against a same cycle clear");
    mask_write_a: assert property (mask_write_s |=> st_r.irq_mask == $past(wb_dat_i[2:0]))
        else $error("interrupt mask write did not land on the acknowledge edge");
    irq_level_a: assert property ((ce && |(st_nxt.irq_stat & st_nxt.irq_mask)) |=> irq)
        else $error("interrupt low while an unmasked event is pending");
endmodule

// *** rtl/mtc_edge_cond.sv ***
`timescale 1ns/10ps
`include "mtc_cfg.svh"
module mtc_edge_cond import mtc_pkg::*; (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic pin,
    input wire logic en_pin,
    input wire logic falling,
    output logic ev
);
    mtc_cond_t st_r;
    mtc_cond_t st_nxt;
    logic lvl;
    logic lvl_d;

    // ************************************************************
    // sync, polarity, enable window, recovery holdoff
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_sync = {st_r.pin_sync[0], pin};
        st_nxt.en_sync = {st_r.en_sync[0], en_pin};
        st_nxt.pin_d = st_r.pin_sync[1];
        lvl = st_r.pin_sync[1] ^ falling;
        lvl_d = st_r.pin_d ^ falling;
        st_nxt.ev = lvl && !lvl_d && st_r.en_sync[1] && (st_r.hold == 2'h0);
        if (st_nxt.ev) begin
            st_nxt.hold = 2'(`MTC_DEAD_CYC - 1);
        end else if (st_r.hold != 2'h0) begin
            st_nxt.hold = st_r.hold - 2'h1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign ev = st_r.ev;

    dead_time_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (ce && st_r.ev) |=> !st_r.ev) else $error("stop accepted inside recovery time");
endmodule

// *** rtl/mtc_pkg.sv ***
package mtc_pkg;
    // ************************************************************
    // state types
    // ************************************************************
    typedef enum logic [1:0] {MS_IDLE = 2'b00, MS_RUN = 2'b01, MS_DONE = 2'b10} mtc_meas_t;
    typedef enum logic [1:0] {CMD_IDLE = 2'b00, CMD_LOW = 2'b01, CMD_HIGH = 2'b10} mtc_cmd_t;

    typedef struct packed {
        logic [1:0] pin_sync;
        logic pin_d;
        logic [1:0] en_sync;
        logic [1:0] hold;
        logic ev;
    } mtc_cond_t;

    typedef struct packed {
        logic [7:0][15:0] mem;
        logic [15:0] rdata;
    } mtc_mem_t;

    typedef struct packed {
        logic [4:0] ctrl;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        mtc_meas_t meas;
        logic timeout;
        logic [11:0] tcnt;
        logic [2:0] cnt1;
        logic [2:0] cnt2;
        logic [7:0][15:0] hits;
        logic [3:0] sel_a;
        logic [3:0] sel_b;
        logic [2:0] slot;
        logic [16:0] diff_last;
        mtc_cmd_t cmd;
        logic wb_busy;
        logic wb_ack;
        logic [31:0] wb_dat;
        logic irq;
    } mtc_core_t;
endpackage

// *** rtl/mtc_result_mem.sv ***
`timescale 1ns/10ps
module mtc_result_mem import mtc_pkg::*; (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic we,
    input wire logic [2:0] waddr,
    input wire logic [15:0] wdata,
    input wire logic [2:0] raddr,
    output logic [15:0] rdata
);
    mtc_mem_t st_r;
    mtc_mem_t st_nxt;

    // ************************************************************
    // eight result words, registered read
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        if (we) begin
            st_nxt.mem[waddr] = wdata;
        end
        st_nxt.rdata = st_r.mem[raddr];
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
endmodule

// *** test/mtc_pulse_src.sv ***
`timescale 1ns/10ps
module mtc_pulse_src (
    input wire logic core_clk,
    output logic start_pin,
    output logic stop1_pin,
    output logic stop2_pin,
    output logic stop1_en_pin,
    output logic stop2_en_pin
);
    logic [2:0] act_r = 3'h0;
    logic [2:0] idle_r = 3'h0;
    // ********
    // pulse sources: idle level flipped while a pulse is on
    // ********
    assign start_pin = idle_r[0] ^ act_r[0];
    assign stop1_pin = idle_r[1] ^ act_r[1];
    assign stop2_pin = idle_r[2] ^ act_r[2];
    initial begin
        stop1_en_pin = 1'b1;
        stop2_en_pin = 1'b1;
    end
    // one cycle pulse on the pins in m, then gap idle cycles
    task fire(input logic [2:0] m, input int gap);
        @(posedge core_clk);
        act_r <= m;
        @(posedge core_clk);
        act_r <= 3'h0;
        repeat (gap) @(posedge core_clk);
    endtask
    task start_meas;
        fire(3'h1, 0);
        repeat (4) @(posedge core_clk); // stops only after start has settled
    endtask
    task set_en(input logic e1, input logic e2);
        @(posedge core_clk);
        stop1_en_pin <= e1;
        stop2_en_pin <= e2;
    endtask
    task set_idle(input logic [2:0] v);
        @(posedge core_clk);
        idle_r <= v;
    endtask
endmodule

// *** test/multihit_time_interval_capture_test.sv ***
`timescale 1ns/10ps
`include "mtc_cfg.svh"
module multihit_time_interval_capture_test;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq, start_pin, stop1_pin, stop2_pin, stop1_en_pin, stop2_en_pin;
    int err_total = 0;
    int n_tests = 0;
    logic [31:0] q, q2;

    always #4 core_clk = ~core_clk;

    mtc_core dut (.core_clk(core_clk), .arst_n(arst_n), .ce(1'b1),
        .start_pin(start_pin), .stop1_pin(stop1_pin), .stop2_pin(stop2_pin),
        .stop1_en_pin(stop1_en_pin), .stop2_en_pin(stop2_en_pin),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));

    mtc_pulse_src src (.core_clk(core_clk), .start_pin(start_pin), .stop1_pin(stop1_pin),
        .stop2_pin(stop2_pin), .stop1_en_pin(stop1_en_pin), .stop2_en_pin(stop2_en_pin));

    // ********
    // bus and compare tasks
    // ********
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 64);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 64) chk("bus ack", 32'h1, 32'h0);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(nm, e, r & m);
    endtask
    task diff(input logic [3:0] a, input logic [3:0] b, input logic [2:0] s, output logic [31:0] r);
        wr(`MTC_ADR_DIFF_CMD, {21'h0, s, b, a});
        bus(1'b0, `MTC_ADR_DIFF_LAST, 32'h0, r);
    endtask
    task irq_chk(input string nm, input logic e);
        repeat (3) @(posedge core_clk);
        chk(nm, {31'h0, e}, {31'h0, irq});
    endtask

    // ********
    // scenarios
    // ********
    task t_regs;
        rchk("ctrl reset", `MTC_ADR_CTRL, 32'hffffffff, 32'h0);
        rchk("status reset", `MTC_ADR_STATUS, 32'hffffffff, 32'h0);
        rchk("mask reset", `MTC_ADR_IRQ_MASK, 32'hffffffff, 32'h0);
        rchk("unmapped read", 8'h18, 32'hffffffff, 32'h0);
        wr(`MTC_ADR_CTRL, 32'h1e);
        rchk("ctrl rw", `MTC_ADR_CTRL, 32'hffffffff, 32'h1e);
        wr(`MTC_ADR_CTRL, 32'h0);
    endtask
    task t_cross;
        src.start_meas();
        src.fire(3'h6, 0);
        src.fire(3'h4, 0);
        src.fire(3'h2, 0);
        repeat (6) @(posedge core_clk);
        diff(4'h0, 4'h4, 3'h0, q);
        chk("cross zero", 32'h0, q);
        diff(4'h1, 4'h5, 3'h3, q);
        chk("cross negative", 32'hffffffc0, q);
        rchk("result slot", 8'h2c, 32'hffff, 32'hffc0);
        diff(4'h0, 4'h1, 3'h0, q);
        chk("same channel", 32'h80, q);
        diff(4'h8, 4'h0, 3'h0, q);
        diff(4'h8, 4'h1, 3'h0, q2);
        chk("stop vs start", 32'h80, q2 - q);
        wr(`MTC_ADR_CTRL, 32'h10);
        diff(4'h1, 4'h5, 3'h3, q);
        rchk("cal low", 8'h28, 32'hffff, 32'hffc0);
        rchk("cal high", 8'h2c, 32'hffff, 32'hffff);
        wr(`MTC_ADR_CTRL, 32'h0);
        rchk("hit flag", `MTC_ADR_IRQ_STAT, 32'h1, 32'h1);
        irq_chk("irq masked", 1'b0);
    endtask
    task t_limits;
        src.set_en(1'b1, 1'b0);
        src.start_meas();
        repeat (5) src.fire(3'h6, 1);
        repeat (4) @(posedge core_clk);
        rchk("four hits", `MTC_ADR_STATUS, 32'h1ff, 32'h44);
        diff(4'h0, 4'h3, 3'h0, q);
        chk("hit spacing", 32'h120, q);
        src.set_en(1'b1, 1'b1);
    endtask
    task t_queue;
        wr(`MTC_ADR_CTRL, 32'h1);
        src.start_meas();
        repeat (6) src.fire(3'h6, 1);
        repeat (4) @(posedge core_clk);
        rchk("queue counts", `MTC_ADR_STATUS, 32'h1ff, 32'h54);
        diff(4'h3, 4'h4, 3'h0, q);
        chk("queue overflow", 32'h60, q);
        wr(`MTC_ADR_CTRL, 32'h0);
    endtask
    task t_edge;
        src.set_idle(3'h2);
        wr(`MTC_ADR_CTRL, 32'h4);
        src.start_meas();
        src.fire(3'h2, 1);
        src.fire(3'h2, 1);
        repeat (4) @(posedge core_clk);
        rchk("falling stops", `MTC_ADR_STATUS, 32'h3f, 32'h2);
        wr(`MTC_ADR_CTRL, 32'h0);
        src.set_idle(3'h0);
    endtask
    task t_timeout;
        wr(`MTC_ADR_IRQ_STAT, 32'h7);
        wr(`MTC_ADR_IRQ_MASK, 32'h4);
        src.start_meas();
        repeat (1990) @(posedge core_clk);
        rchk("still running", `MTC_ADR_STATUS, 32'hc0, 32'h40);
        repeat (60) @(posedge core_clk);
        src.fire(3'h2, 1);
        repeat (4) @(posedge core_clk);
        rchk("timeout status", `MTC_ADR_STATUS, 32'h1ff, 32'h80);
        rchk("timeout flags", `MTC_ADR_IRQ_STAT, 32'h7, 32'h6);
        irq_chk("irq raised", 1'b1);
        wr(`MTC_ADR_IRQ_MASK, 32'h0);
        irq_chk("irq mask off", 1'b0);
        wr(`MTC_ADR_IRQ_MASK, 32'h4);
        irq_chk("irq mask on", 1'b1);
        wr(`MTC_ADR_IRQ_STAT, 32'h4);
        irq_chk("irq cleared", 1'b0);
        rchk("flag w1c", `MTC_ADR_IRQ_STAT, 32'h7, 32'h2);
    endtask

    // ********
    // run
    // ********
    initial begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        t_regs();
        t_cross();
        t_limits();
        t_queue();
        t_edge();
        t_timeout();
        give_verdict();
    end
    initial begin
        repeat (10000) @(posedge core_clk);
        err_total++;
        give_verdict();
    end
endmodule
